// [include/ubt_pkg.sv]
/*
 * package for the upstream burst timing front end: modes, rates, timing constants.
 * assumes a single 200 MHz system clock; no software-visible registers.
 */
package ubt_pkg;

    // clock and slot timing
    localparam int  CLK_MHZ          = 200;
    localparam real SLOT_US          = 6.25;                      // minislot tick
    localparam int  SLOT_CYC         = int'(SLOT_US * CLK_MHZ);   // 1250 cycles
    localparam int  SLOT_SYMS        = 16;                        // symbols per tick at fastest rate
    localparam int  FAST_RATE_KSPS   = 2560;
    // cycles per symbol at fastest rate, derived from tick length
    localparam int  SYM_CYC_FAST     = SLOT_CYC / SLOT_SYMS;      // 78 (round down)
    localparam int  GUARD_SYMS_MIN   = 5;
    localparam int  GUARD_TIME_ADJ   = 1;                         // guard time = band minus one

    // modulation formats
    typedef enum logic [0:0] {UBT_QPSK, UBT_QAM16} ubt_mod_t;

    // five symbol rates: divider shift from fastest rate
    typedef enum logic [2:0] {
        UBT_R2560, UBT_R1280, UBT_R640, UBT_R320, UBT_R160
    } ubt_rate_t;

    localparam logic [14:0] SCR_SEED_RST = 15'h0000;
    localparam logic [14:0] SCR_TAPS     = 15'h6000;               // x15 + x14 + 1 feedback

    // default preamble length in pattern bytes
    localparam logic [7:0]  PRE_LEN_RST  = 8'h00;

endpackage

// [core/ubt_fifo.sv]
/*
 * parameterised synchronous fifo with valid/ready on both sides.
 * assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
module ubt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("ubt_fifo: depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    ////////////////////////////////////////////////////////////////////////
    // honest full/empty from the extra pointer bit
    assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data  = mem[rd_q[AW-1:0]];
    assign level     = wr_q - rd_q;

    // storage has no reset; contents are only read when valid
    always_ff @(posedge clk_sys) begin
        if (push) mem[wr_q[AW-1:0]] <= in_data;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop)  rd_q <= rd_q + 1'b1;
        end
    end
endmodule

// [core/ubt_burst_tx.sv]
/*
 * upstream burst transmit front end: buffers one burst of mac bytes, then at
 * the scheduled tick prepends preamble, scrambles, maps and emits symbols.
 * assumes the mac side presents a whole burst with last marked, and the
 * headend time reference arrives as a pin pulse marking tick zero.
 */
`timescale 1ns/1ps
module ubt_burst_tx
    import ubt_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int SLOT_CYCLES = SLOT_CYC
) (
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    // headend time reference pin, one pulse per tick zero
    input  wire logic                 time_ref_pin,
    // per-burst settings, sampled with the first byte; cfg_scr_seed taken while waiting for the tick
    input  wire ubt_pkg::ubt_mod_t    cfg_mod,
    input  wire ubt_pkg::ubt_rate_t   cfg_rate,
    input  wire logic [7:0]           cfg_pre_len,
    input  wire logic [7:0]           cfg_pre_pat,
    input  wire logic                 cfg_scr_en,
    input  wire logic [14:0]          cfg_scr_seed,
    input  wire logic                 cfg_diff_en,
    input  wire logic [15:0]          cfg_start_tick,
    input  wire logic                 cfg_overlap,
    // mac byte stream
    input  wire logic [7:0]           mac_data,
    input  wire logic                 mac_last,
    input  wire logic                 mac_valid,
    output logic                      mac_ready,
    // symbol stream to the shaping modulator
    output logic [3:0]                sym_data,
    output logic                      sym_valid,
    output logic                      sym_first,
    output logic                      sym_last,
    output logic                      sym_is_qam16,
    output logic                      ramp_hold,
    output logic [15:0]               tick_count,
    output logic                      busy
);
    localparam int TW = $clog2(SLOT_CYCLES);
    initial begin
        if (FIFO_DEPTH != 16) $error("ubt_burst_tx: burst buffer sized for 16 words");
        if (SLOT_CYCLES < SLOT_SYMS) $error("ubt_burst_tx: tick too short");
    end
    typedef enum logic [2:0] {S_FILL, S_WAIT, S_PRE, S_DATA, S_DONE} ubt_state_t;
    // one step of the scrambler lfsr
    function automatic logic [14:0] scr_step(input logic [14:0] s);
        return {s[13:0], ^(s & SCR_TAPS)};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // time reference synchroniser and local tick timebase
    logic       ref_s1_q, ref_s2_q, ref_s3_q;
    logic [TW-1:0] tcnt_q;
    logic [15:0]   tick_q;
    wire        ref_edge = ref_s2_q && !ref_s3_q;
    wire        tick_end = tcnt_q == TW'(SLOT_CYCLES - 1);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
            ref_s3_q <= 1'b0;
        end else begin
            ref_s1_q <= time_ref_pin;
            ref_s2_q <= ref_s1_q;
            ref_s3_q <= ref_s2_q;
        end
    end

    // tick counter realigned on each reference edge
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tcnt_q <= '0;
            tick_q <= '0;
        end else if (ref_edge) begin
            tcnt_q <= '0;
            tick_q <= '0;
        end else if (tick_end) begin
            tcnt_q <= '0;
            tick_q <= tick_q + 16'h0001;
        end else begin
            tcnt_q <= tcnt_q + 1'b1;
        end
    end
    assign tick_count = tick_q;

    ////////////////////////////////////////////////////////////////////////
    // burst buffer; fill side stalls while a burst is in flight
    ubt_state_t    st_q, st_d;
    logic [7:0]    fb_data;
    logic          fb_valid, fb_ready, fi_ready;
    logic [4:0]    fb_level;
    logic [4:0]    count_q;
    logic          last_seen_q;
    wire           fill_ok = (st_q == S_FILL) && !last_seen_q;
    wire           push    = mac_valid && mac_ready;

    assign mac_ready = fi_ready && fill_ok;

    ubt_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_buf (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_data   (mac_data),
        .in_valid  (mac_valid && fill_ok),
        .in_ready  (fi_ready),
        .out_data  (fb_data),
        .out_valid (fb_valid),
        .out_ready (fb_ready),
        .level     (fb_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // burst settings latched with the first byte
    ubt_mod_t    mod_q;
    ubt_rate_t   rate_q;
    logic [7:0]  pre_len_q, pre_pat_q;
    logic        scr_en_q, diff_q, ovl_q;
    logic [14:0] scr_q;
    logic [15:0] start_q;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mod_q     <= UBT_QPSK;
            rate_q    <= UBT_R2560;
            pre_len_q <= PRE_LEN_RST;
            pre_pat_q <= 8'h00;
            scr_en_q  <= 1'b0;
            diff_q    <= 1'b0;
            ovl_q     <= 1'b0;
            start_q   <= 16'h0000;
        end else if (push && count_q == 5'h00) begin
            mod_q     <= cfg_mod;
            rate_q    <= cfg_rate;
            pre_len_q <= cfg_pre_len;
            pre_pat_q <= cfg_pre_pat;
            scr_en_q  <= cfg_scr_en;
            diff_q    <= cfg_diff_en;
            ovl_q     <= cfg_overlap;
            start_q   <= cfg_start_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // symbol-rate enable: fastest symbol period shifted by the rate code
    logic [11:0] sdiv_q;
    wire  [11:0] sym_period = 12'(SYM_CYC_FAST) << rate_q;
    wire         sym_en     = sdiv_q == 12'h000;
    wire         sending    = (st_q == S_PRE) || (st_q == S_DATA);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) sdiv_q <= 12'h000;
        else if (!sending || sym_en) sdiv_q <= sym_period - 12'h001;
        else sdiv_q <= sdiv_q - 12'h001;
    end

    ////////////////////////////////////////////////////////////////////////
    // symbol builder: shifts bits msb first, qpsk 2 bits, 16qam 4 bits
    logic [7:0]  sh_q;
    logic [2:0]  bits_q;           // symbols left in shift register
    logic [7:0]  pre_cnt_q;        // pattern bytes left, four symbols each
    logic [1:0]  quad_q;           // previous quadrant for differential
    wire  [2:0]  bps      = (mod_q == UBT_QAM16) ? 3'd4 : 3'd2;
    wire  [3:0]  raw_sym  = (mod_q == UBT_QAM16) ? sh_q[7:4] : {sh_q[7:6], 2'b00};
    wire  [1:0]  ph       = {raw_sym[3], raw_sym[2]};
    // quadrant rotation by gray phase code: 00/0, 01/90, 11/180, 10/270
    wire  [1:0]  rot      = {ph[1], ph[1] ^ ph[0]};
    wire  [1:0]  new_quad = diff_q ? rotate(quad_q, rot) : ph;
    wire         need_ld  = bits_q == 3'd0;
    wire         data_ld  = (st_q == S_DATA) && need_ld && fb_valid;
    wire         pre_ld   = (st_q == S_PRE) && need_ld;
    wire         emit     = sending && sym_en && !need_ld;
    wire         scr_bit  = scr_en_q && (st_q == S_DATA);
    // quadrant after n quarter turns around the ring 11,01,00,10; ring index is {~q0, q1^q0}
    function automatic logic [1:0] rotate(input logic [1:0] q, input logic [1:0] n);
        logic [1:0] idx;
        idx = 2'({~q[0], q[1] ^ q[0]} + n);    // wraps around the ring on purpose
        return {~(idx[1] ^ idx[0]), ~idx[1]};
    endfunction
    assign fb_ready = data_ld;
    // scrambled byte: xor each bit with successive lfsr output
    logic [7:0]  scr_byte;
    logic [14:0] scr_nx;
    always_comb begin
        scr_nx   = scr_q;
        scr_byte = fb_data;
        for (int i = 7; i >= 0; i--) begin
            if (scr_bit) scr_byte[i] = fb_data[i] ^ scr_nx[14];
            if (scr_bit) scr_nx = scr_step(scr_nx);
        end
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sh_q      <= 8'h00;
            bits_q    <= 3'd0;
            pre_cnt_q <= 8'h00;
            quad_q    <= 2'b00;
            scr_q     <= SCR_SEED_RST;
        end else if (st_q == S_WAIT) begin
            bits_q    <= 3'd0;
            pre_cnt_q <= pre_len_q;
            quad_q    <= 2'b00;
            scr_q     <= cfg_scr_seed;
        end else if (pre_ld && pre_cnt_q != 8'h00) begin
            sh_q      <= pre_pat_q;
            bits_q    <= 3'd4;                    // preamble always two-bit symbols
            pre_cnt_q <= pre_cnt_q - 8'h01;
        end else if (data_ld) begin
            sh_q      <= scr_byte;
            bits_q    <= (mod_q == UBT_QAM16) ? 3'd2 : 3'd4;   // symbols per byte
            scr_q     <= scr_nx;
        end else if (emit) begin
            sh_q      <= sh_q << ((st_q == S_PRE) ? 2 : bps);
            bits_q    <= bits_q - 3'd1;
            quad_q    <= new_quad;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // burst sequence: fill, wait for tick, preamble, payload
    always_comb st_d = next_state(st_q);   // a process, so reads inside the function wake it
    function automatic ubt_state_t next_state(input ubt_state_t s);
        case (s)
            S_FILL:  return last_seen_q ? S_WAIT : S_FILL;
            // start exactly at the scheduled tick edge
            S_WAIT:  return (tick_end && (tick_q + 16'h0001) == start_q) ? S_PRE : S_WAIT;
            S_PRE:   return (pre_cnt_q == 8'h00 && need_ld) ? S_DATA : S_PRE;
            S_DATA:  return (!fb_valid && need_ld) ? S_DONE : S_DATA;
            S_DONE:  return S_FILL;
            default: return S_FILL;
        endcase
    endfunction
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_q        <= S_FILL;
            count_q     <= 5'h00;
            last_seen_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (push) count_q <= count_q + 5'h01;
            if (push && (mac_last || count_q == 5'(FIFO_DEPTH - 1))) last_seen_q <= 1'b1;
            if (st_q == S_DONE) begin
                count_q     <= 5'h00;
                last_seen_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output symbol register; gapless once started
    logic first_q;
    wire  emit_last = emit && (st_q == S_DATA) && bits_q == 3'd1 && !fb_valid;   // guard counts from here

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sym_data     <= 4'h0;
            sym_valid    <= 1'b0;
            sym_first    <= 1'b0;
            sym_last     <= 1'b0;
            sym_is_qam16 <= 1'b0;
            first_q      <= 1'b0;
        end else begin
            sym_valid <= emit;
            sym_first <= emit && first_q;
            sym_last  <= emit_last;
            if (st_q == S_WAIT) first_q <= 1'b1;
            else if (emit) first_q <= 1'b0;
            if (emit) begin
                sym_data     <= {new_quad, (st_q == S_DATA && mod_q == UBT_QAM16) ? raw_sym[1:0] : 2'b00};
                sym_is_qam16 <= (st_q == S_DATA) && (mod_q == UBT_QAM16);
            end
        end
    end

    // ramp hold tells the shaper not to ramp down between overlapping bursts
    assign ramp_hold = ovl_q && (st_q != S_FILL || fb_level != 5'h00);
    assign busy      = st_q != S_FILL;
endmodule

// [tb/ubt_burst_tx_assertions.sv]
/*
 * port-level checks on the burst transmit front end, bound into it.
 * assumes burst settings stay put while a burst is in flight.
 */
`timescale 1ns/1ps
module ubt_burst_tx_checker #(
    parameter int SLOT_CYCLES = ubt_pkg::SLOT_CYC
) (
    input wire logic               clk_sys,
    input wire logic               sys_rst,
    input wire ubt_pkg::ubt_mod_t  cfg_mod,
    input wire ubt_pkg::ubt_rate_t cfg_rate,
    input wire logic [15:0]        cfg_start_tick,
    input wire logic               mac_valid,
    input wire logic               mac_last,
    input wire logic               mac_ready,
    input wire logic [3:0]         sym_data,
    input wire logic               sym_valid,
    input wire logic               sym_first,
    input wire logic               sym_last,
    input wire logic               sym_is_qam16,
    input wire logic [15:0]        tick_count,
    input wire logic               busy
);
    import ubt_pkg::*;
    logic [11:0] gap_q, since_q, per;
    logic [15:0] tick_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////
    // symbol period of the burst in flight
    assign per = 12'(SYM_CYC_FAST) << cfg_rate;
    // saturating ages, so long idles never wrap into a false match
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            gap_q   <= 12'h000;
            since_q <= 12'h000;
            tick_q  <= 16'h0000;
        end else begin
            gap_q   <= sym_valid ? 12'h001 : gap_q + 12'(~&gap_q);
            since_q <= (tick_count != tick_q) ? 12'h000 : since_q + 12'(~&since_q);
            tick_q  <= tick_count;
        end
    end
    ////////////////////////////////////////////////////////////
    sequence s_take_last;
        mac_valid && mac_ready && mac_last;
    endsequence
    sequence s_burst_end;
        sym_valid && sym_last;
    endsequence
    a_first_valid: assert property (sym_first |-> sym_valid)
        else $error("first marker without symbol");
    a_qpsk_low_bits: assert property (sym_valid && !sym_is_qam16 |-> sym_data[1:0] == 2'b00)
        else $error("two-bit symbol has low bits");
    a_mac_refused: assert property (sym_valid |-> !mac_ready && busy)
        else $error("bytes open while on air");
    a_last_closes: assert property (s_take_last |=> !mac_ready [*2])
        else $error("bytes open after burst end");
    a_sym_spacing: assert property (sym_valid && !sym_first |-> gap_q == per)
        else $error("symbol spacing off");
    a_mod_steady: assert property (sym_valid && (cfg_mod == UBT_QPSK) |-> !sym_is_qam16)
        else $error("format changed in burst");
    a_burst_quiet: assert property (s_burst_end |=> !sym_valid [*8])
        else $error("symbols after burst end");
    a_start_latency: assert property (sym_first |-> since_q <= per + 12'd8)
        else $error("burst start late after tick");
    a_start_tick: assert property (sym_first && (int'(per) + 8 < SLOT_CYCLES) |-> tick_count == cfg_start_tick)
        else $error("burst started on wrong tick");
endmodule
bind ubt_burst_tx ubt_burst_tx_checker #(.SLOT_CYCLES(SLOT_CYCLES)) u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_mod(cfg_mod), .cfg_rate(cfg_rate), .cfg_start_tick(cfg_start_tick),
    .mac_valid(mac_valid), .mac_last(mac_last), .mac_ready(mac_ready), .sym_data(sym_data),
    .sym_valid(sym_valid), .sym_first(sym_first), .sym_last(sym_last), .sym_is_qam16(sym_is_qam16),
    .tick_count(tick_count), .busy(busy));

// [tb/ubt_headend_model.sv]
/*
 * headend side: time reference pulses, slot gating and burst capture.
 * assumes the bench reads rx_q and bursts between bursts.
 */
`timescale 1ns/1ps
module ubt_headend_model (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic [3:0] sym_data,
    input  wire logic       sym_valid,
    input  wire logic       sym_first,
    input  wire logic       sym_last,
    output logic            time_ref_pin,
    output logic            slot_gate
);
    logic [3:0] rx_q[$];
    int         bursts;
    int         since_ref;
    int         lead;
    initial time_ref_pin = 1'b0;
    // a few cycles wide, so the synchroniser cannot miss it
    task automatic send_ref();
        @(negedge clk_sys);
        time_ref_pin = 1'b1;
        repeat (4) @(negedge clk_sys);
        time_ref_pin = 1'b0;
    endtask
    // acquisition gated per burst; opened by the first marker, closed by the last
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            slot_gate <= 1'b0;
            bursts <= 0;
            since_ref <= 0;
        end else begin
            since_ref <= time_ref_pin ? 0 : since_ref + 1;
            if (sym_first) slot_gate <= 1'b1;
            if (sym_first) lead <= since_ref; // timing estimate
            if (sym_valid && (slot_gate || sym_first)) rx_q.push_back(sym_data);
            if (sym_last) slot_gate <= 1'b0;
            if (sym_last) bursts <= bursts + 1;
        end
    end
endmodule

// [tb/tb_top.sv]
/*
 * self-checking bench: bursts built from a reference model and compared.
 * assumes the headend model and bound checker compile alongside.
 */
`timescale 1ns/1ps
module tb_top;
    import ubt_pkg::*;
    localparam int SLOT = 200; // short tick keeps the run brief
    logic clk_sys, sys_rst, time_ref_pin, slot_gate, cfg_scr_en, cfg_diff_en, cfg_overlap;
    logic mac_last, mac_valid, mac_ready, sym_valid, sym_first, sym_last, sym_is_qam16, ramp_hold, busy;
    ubt_mod_t    cfg_mod;
    ubt_rate_t   cfg_rate;
    logic [7:0]  cfg_pre_len, cfg_pre_pat, mac_data;
    logic [14:0] cfg_scr_seed;
    logic [15:0] cfg_start_tick, tick_count;
    logic [3:0]  sym_data;
    logic [4:0]  exp_q[$]; // bit 4 marks a preamble symbol
    int          n_fail, checks_done, k, t0, v;
    int          qi[4] = '{2, 1, 3, 0};
    int          di[4] = '{0, 1, 3, 2};
    logic [1:0]  qv[4] = '{2'b11, 2'b01, 2'b00, 2'b10};
    ////////////////////////////////////////////////////////////
    ubt_burst_tx #(.SLOT_CYCLES(SLOT)) DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .time_ref_pin(time_ref_pin), .cfg_mod(cfg_mod),
        .cfg_rate(cfg_rate), .cfg_pre_len(cfg_pre_len), .cfg_pre_pat(cfg_pre_pat), .cfg_scr_en(cfg_scr_en),
        .cfg_scr_seed(cfg_scr_seed), .cfg_diff_en(cfg_diff_en), .cfg_start_tick(cfg_start_tick),
        .cfg_overlap(cfg_overlap), .mac_data(mac_data), .mac_last(mac_last), .mac_valid(mac_valid),
        .mac_ready(mac_ready), .sym_data(sym_data), .sym_valid(sym_valid), .sym_first(sym_first),
        .sym_last(sym_last), .sym_is_qam16(sym_is_qam16), .ramp_hold(ramp_hold), .tick_count(tick_count),
        .busy(busy));
    ubt_headend_model u_he (.clk_sys(clk_sys), .sys_rst(sys_rst), .sym_data(sym_data), .sym_valid(sym_valid),
        .sym_first(sym_first), .sym_last(sym_last), .time_ref_pin(time_ref_pin), .slot_gate(slot_gate));
    ////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one burst: load bytes, predict symbols, compare what the headend caught
    task automatic burst(input int n, input int m, input int r, input int pl, input logic scr, input logic dif);
        logic [3:0] g;
        int i, sh, w, b0, diffs;
        w = m ? 4 : 2;
        b0 = u_he.bursts;
        @(negedge clk_sys);
        cfg_mod = ubt_mod_t'(m);
        cfg_rate = ubt_rate_t'(r);
        cfg_pre_len = 8'(pl);
        cfg_pre_pat = 8'($urandom);
        cfg_scr_en = scr;
        cfg_diff_en = dif;
        cfg_scr_seed = 15'($urandom) | 15'h0001;
        cfg_overlap = 1'($urandom);
        cfg_start_tick = tick_count + 16'h0002; // a spare tick as guard
        exp_q.delete();
        u_he.rx_q.delete();
        // preamble length counts pattern bytes, four two-bit symbols each
        for (i = 0; i < 4 * pl; i++) exp_q.push_back({1'b1, cfg_pre_pat[6 - 2 * (i % 4) +: 2], 2'b00});
        for (i = 0; i < n; i++) begin
            mac_data = 8'($urandom);
            mac_last = (i == n - 1) && (n < 16);
            mac_valid = 1'b1;
            for (sh = 8 - w; sh >= 0; sh -= w)
                exp_q.push_back(m ? {1'b0, mac_data[sh +: 4]} : {1'b0, mac_data[sh +: 2], 2'b00});
            #1 chk(16'(mac_ready), 16'h0001);
            @(negedge clk_sys);
        end
        mac_valid = 1'b0;
        mac_last = 1'b0;
        #1 chk(16'(mac_ready), 16'h0000);
        chk(16'(ramp_hold), 16'(cfg_overlap));
        for (i = 0; i < 40000 && u_he.bursts == b0; i++) @(negedge clk_sys);
        chk(16'(u_he.rx_q.size()), 16'(exp_q.size()));
        diffs = 0;
        for (i = 0; i < exp_q.size() && i < u_he.rx_q.size(); i++) begin
            g = u_he.rx_q[i];
            if (scr && !exp_q[i][4]) diffs += int'(g !== exp_q[i][3:0]);
            else if (!dif) chk(exp_q[i][4] ? {g[3:2], 2'b00} : g, exp_q[i][3:0]);
            else chk(g[3:2], qv[(qi[(i > 0) ? u_he.rx_q[i - 1][3:2] : 2'b00] + di[exp_q[i][3:2]]) % 4]);
        end
        if (scr) chk(16'(diffs > 0), 16'h0001);
        for (i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk_sys);
        chk(16'(busy), 16'h0000);
        chk(16'(ramp_hold), 16'h0000);
        chk(16'(slot_gate), 16'h0000);
        $display("burst of %0d bytes done, mode %0d rate %0d", n, m, r);
    endtask
    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(32'h3694));
        {cfg_scr_en, cfg_diff_en, cfg_overlap, mac_last, mac_valid} = '0;
        {cfg_pre_len, cfg_pre_pat, mac_data, cfg_scr_seed, cfg_start_tick} = '0;
        cfg_mod = UBT_QPSK;
        cfg_rate = UBT_R2560;
        n_fail = 0;
        checks_done = 0;
        sys_rst = 1'b1;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({sym_valid, sym_first, sym_last, busy, mac_ready}, 16'h0001);
        sys_rst = 1'b0;
        repeat (3 * SLOT) @(negedge clk_sys);
        u_he.send_ref();
        repeat (8) @(negedge clk_sys);
        chk(tick_count, 16'h0000);
        for (k = 0; k < 2; k++) begin
            v = tick_count;
            for (t0 = 0; tick_count == 16'(v) && t0 < 4 * SLOT; t0++) @(negedge clk_sys);
        end
        chk(16'(t0), 16'(SLOT));
        $display("timebase test done");
        for (k = 0; k < 10; k++) burst(1, k / 5, k % 5, 1, 1'b0, 1'b0);
        burst(16, 1, 0, 8, 1'b0, 1'b0);
        burst(4, 0, 0, 8, 1'b0, 1'b1);
        burst(8, 0, 0, 4, 1'b1, 1'b0);
        repeat (4) burst(1 + $urandom % 8, $urandom % 2, $urandom % 2, 1 + $urandom % 4, 1'b0, 1'b0);
        tally_and_finish();
    end
    // watchdog against a hung handshake
    initial begin
        // slow-rate sweep dominates; all tests need about 85k cycles at worst
        #(100000 * 5);
        n_fail++;
        $display("watchdog expired at %0t", $time);
        tally_and_finish();
    end
endmodule
